// *** ldc3_defs.vh ***
// constants for the third driver control word bank
// assumes a 16-bit serial-side word interface and a 50 MHz clock
`ifndef LDC3_DEFS_VH
`define LDC3_DEFS_VH
// How it works
// - an over-current on channel 7..11 sets its flag and turns that channel off.
// - with its recovery bit (15..11) set a tripped channel re-enables itself after a delay.
// - with recovery cleared a tripped channel stays flagged and off until the host clears its flag.
// - with its pwm enable set and the channel on, the output follows its pwm input.
// - channels 8 and 10 (bits 9, 7) follow pwm input b, channels 7, 9, 11 (bits 10, 8, 6) input a.
// - bit 5 picks recovery frequency, 0 for 1.7 kHz and 1 for 3 kHz.
// - with bit 4 set outputs stay off after a supply fault until the host clears status.
// - the tripped output goes off and is flagged whether or not recovery is enabled.
`define LDC3_WIDTH 16
`define LDC3_RESET 16'h0000
`define LDC3_OCR_MSB 15
`define LDC3_OCR_LSB 11
`define LDC3_PWM_MSB 10
`define LDC3_PWM_LSB 6
`define LDC3_FREQ_BIT 5
`define LDC3_MANUAL_BIT 4
`define LDC3_MON_MSB 3
`define LDC3_MON_LSB 0
`define LDC3_MON_LAST 4'ha
`define LDC3_PWM_B_MASK 5'h0a
`define LDC3_CLK_HZ 50000000
`define LDC3_FREQ_SLOW_HZ 1700
`define LDC3_FREQ_FAST_HZ 3000
`define LDC3_PERIOD_SLOW (`LDC3_CLK_HZ / `LDC3_FREQ_SLOW_HZ)
`define LDC3_PERIOD_FAST (`LDC3_CLK_HZ / `LDC3_FREQ_FAST_HZ)
`endif

// *** ldc3_bank.v ***
// third driver control word and the channel 7..11 gating it steers
// assumes word writes from the serial slave on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "ldc3_defs.vh"
module ldc3_bank #(
	parameter SLOW_CYCLES = `LDC3_PERIOD_SLOW,
	parameter FAST_CYCLES = `LDC3_PERIOD_FAST
) (
	input wire clock,
	input wire rst,
	input wire clk_en,
	input wire wr_en,
	input wire [15:0] wr_data,
	output reg [15:0] rd_data,
	input wire [4:0] channel_on,
	input wire [4:0] overcurrent_event,
	input wire [4:0] oc_flag_clear,
	input wire status_clear,
	input wire supply_fault,
	input wire pwm_input_a,
	input wire pwm_input_b,
	output wire [4:0] driver_out,
	output wire [4:0] oc_flag,
	output reg supply_block,
	output reg monitor_enable,
	output reg [3:0] current_image_output
);
// ****************************************
// pin synchronisers
// ****************************************
reg [1:0] pwm_a_q;
reg [1:0] pwm_b_q;
always @(posedge clock)
begin
	if (rst)
	begin
		pwm_a_q <= 2'h0;
		pwm_b_q <= 2'h0;
	end
	else if (clk_en)
	begin
		pwm_a_q <= {pwm_a_q[0], pwm_input_a};
		pwm_b_q <= {pwm_b_q[0], pwm_input_b};
	end
end
// ****************************************
// control word
// ****************************************
reg [15:0] ctrl_q;
always @(posedge clock)
begin
	if (rst)
		ctrl_q <= `LDC3_RESET;
	else if (clk_en && wr_en)
		ctrl_q <= wr_data;
end
wire [4:0] ocr_en = ctrl_q[`LDC3_OCR_MSB:`LDC3_OCR_LSB];
wire [4:0] pwm_en = ctrl_q[`LDC3_PWM_MSB:`LDC3_PWM_LSB];
wire manual_restart = ctrl_q[`LDC3_MANUAL_BIT];
// bit order: index 4 is channel 7, index 0 is channel 11
wire [4:0] pwm_sel = (`LDC3_PWM_B_MASK & {5{pwm_b_q[1]}}) |
	(~`LDC3_PWM_B_MASK & {5{pwm_a_q[1]}});
// ****************************************
// recovery timer
// ****************************************
reg [15:0] rec_cnt_q;
wire [15:0] rec_period = ctrl_q[`LDC3_FREQ_BIT] ?
	FAST_CYCLES[15:0] : SLOW_CYCLES[15:0];
wire rec_tick = (rec_cnt_q >= rec_period - 16'h0001);
always @(posedge clock)
begin
	if (rst)
		rec_cnt_q <= 16'h0000;
	else if (clk_en)
		rec_cnt_q <= rec_tick ? 16'h0000 : rec_cnt_q + 16'h0001;
end
// ****************************************
// supply fault latch
// ****************************************
always @(posedge clock)
begin
	if (rst)
		supply_block <= 1'b0;
	else if (clk_en)
	begin
		if (supply_fault && manual_restart)
			supply_block <= 1'b1;
		else if (status_clear || !manual_restart)
			supply_block <= 1'b0;
	end
end
// live fault blocks at once, latch keeps it while manual_restart (bit 4) is set until status_clear
wire live_block = supply_block | supply_fault;
// ****************************************
// driver channels
// ****************************************
genvar ch;
generate
	for (ch = 0; ch < 5; ch = ch + 1)
	begin : g_chan
		ldc3_chan u_chan (
			.clock(clock),
			.rst(rst),
			.clk_en(clk_en),
			.on(channel_on[ch]),
			.ocr_en(ocr_en[ch]),
			.pwm_en(pwm_en[ch]),
			.pwm_level(pwm_sel[ch]),
			.rec_tick(rec_tick),
			.event_in(overcurrent_event[ch]),
			.flag_clear(oc_flag_clear[ch]),
			.block(live_block),
			.drive_q(driver_out[ch]),
			.flag_q(oc_flag[ch])
		);
	end
endgenerate
// ****************************************
// readback
// ****************************************
always @(posedge clock)
begin
	if (rst)
		rd_data <= 16'h0000;
	else if (clk_en)
		rd_data <= ctrl_q;
end
// ****************************************
// current monitor select
// ****************************************
wire [3:0] mon_code = ctrl_q[`LDC3_MON_MSB:`LDC3_MON_LSB];
reg mon_en_d;
always @*
begin
	case (mon_code)
	4'h0: mon_en_d = 1'b1;
	4'h1: mon_en_d = 1'b1;
	4'h2: mon_en_d = 1'b1;
	4'h3: mon_en_d = 1'b1;
	4'h4: mon_en_d = 1'b1;
	4'h5: mon_en_d = 1'b1;
	4'h6: mon_en_d = 1'b1;
	4'h7: mon_en_d = 1'b1;
	4'h8: mon_en_d = 1'b1;
	4'h9: mon_en_d = 1'b1;
	4'ha: mon_en_d = 1'b1;
	default: mon_en_d = 1'b0;
	endcase
end
always @(posedge clock)
begin
	if (rst)
	begin
		monitor_enable <= 1'b0;
		current_image_output <= 4'h0;
	end
	else if (clk_en)
	begin
		monitor_enable <= mon_en_d;
		current_image_output <= mon_code;
	end
end
endmodule

// one driver channel: trip flag and gated drive
// assumes event and clear pulses on the same clock
module ldc3_chan (
	input wire clock,
	input wire rst,
	input wire clk_en,
	input wire on,
	input wire ocr_en,
	input wire pwm_en,
	input wire pwm_level,
	input wire rec_tick,
	input wire event_in,
	input wire flag_clear,
	input wire block,
	output reg drive_q,
	output reg flag_q
);
// ****************************************
// trip flag
// ****************************************
// event applied last so a trip beats any clear
reg flag_d;
always @*
begin
	flag_d = flag_q;
	if (rec_tick && ocr_en)
		flag_d = 1'b0;
	if (flag_clear)
		flag_d = 1'b0;
	if (event_in)
		flag_d = 1'b1;
end
// ****************************************
// gated drive
// ****************************************
wire gate = on & (~pwm_en | pwm_level);
always @(posedge clock)
begin
	if (rst)
	begin
		flag_q <= 1'b0;
		drive_q <= 1'b0;
	end
	else if (clk_en)
	begin
		flag_q <= flag_d;
		drive_q <= gate & ~flag_d & ~block;
	end
end
endmodule
`default_nettype wire

// *** ldc3_asserts.sv ***
// checker for the control word bank; bound to ldc3_bank ports
`timescale 1ns/10ps
`default_nettype none
module ldc3_asserts(input wire clock,input wire rst,input wire clk_en,
input wire wr_en,input wire [15:0] wr_data,input wire [15:0] rd_data,
input wire [4:0] channel_on,input wire [4:0] oc_flag_clear,
input wire supply_fault,
input wire [4:0] overcurrent_event,input wire [4:0] oc_flag,
input wire [4:0] driver_out,input wire monitor_enable);
default clocking cb @(posedge clock);
endclocking
default disable iff (rst);
a_word_readback: assert property(wr_en&&clk_en##1 clk_en|=>
rd_data==$past(wr_data,2)) else $error("readback wrong");
a_trip_off: assert property(overcurrent_event[4]&&clk_en|=>
oc_flag[4]&&!driver_out[4]) else $error("trip not seen");
a_monitor_off: assert property(wr_en&&clk_en&&wr_data[3:0]>4'ha
##1 clk_en|=>!monitor_enable) else $error("monitor on");
a_freeze_hold: assert property(!clk_en|=>$stable(rd_data)&&
$stable(oc_flag)&&$stable(driver_out)) else $error("moved while frozen");
a_clear_frees: assert property(oc_flag_clear[4]&&clk_en
&&!overcurrent_event[4]|=>!oc_flag[4]) else $error("flag kept");
a_event_wins: assert property(overcurrent_event[0]&&clk_en|=>
oc_flag[0]&&!driver_out[0]) else $error("event lost");
a_supply_off: assert property(supply_fault&&clk_en|=>
driver_out==5'h00) else $error("driver on in supply fault");
a_off_gated: assert property(channel_on==5'h00&&clk_en|=>
driver_out==5'h00) else $error("driver on while off");
c_trip: cover property(overcurrent_event!=5'h00&&clk_en);
c_supply: cover property(supply_fault&&clk_en);
c_frozen_write: cover property(wr_en&&!clk_en);
endmodule
bind ldc3_bank ldc3_asserts u_chk(.*);
`default_nettype wire

// *** ldc3_host.sv ***
// host model: word writes and status clears
`timescale 1ns/10ps
`default_nettype none
module ldc3_host(input wire clock,output logic wr_en=0,
output logic [15:0] wr_data=0,output logic [4:0] oc_flag_clear=0,
output logic status_clear=0);
task put(input logic [15:0] w);
wr_data=w;wr_en=1;@(negedge clock);wr_en=0;wr_data=~w;
endtask
task clear(input logic [4:0] m);
oc_flag_clear=m;@(negedge clock);oc_flag_clear=0;
endtask
task sclr;
status_clear=1;@(negedge clock);status_clear=0;
endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// testbench for ldc3_bank with short recovery periods
`timescale 1ns/10ps
`default_nettype none
module tb;
logic clock=0,rst=1,wr_en,st,sf=0,pa=0,pb=0,mb,me,ce=1;
logic [15:0] wd,rd;
logic [4:0] on=5'h1f,ev=0,fc,dr,fl;
logic [3:0] ci;
logic [31:0] s=32'h6;
int bad_count=0,samples_checked=0,cyc=0;
always #10 clock=~clock;
ldc3_bank #(.SLOW_CYCLES(20),.FAST_CYCLES(10)) u_dut(.clock,.rst,
.clk_en(ce),.wr_en,.wr_data(wd),.rd_data(rd),.channel_on(on),
.overcurrent_event(ev),.oc_flag_clear(fc),.status_clear(st),
.supply_fault(sf),.pwm_input_a(pa),.pwm_input_b(pb),.driver_out(dr),
.oc_flag(fl),.supply_block(mb),.monitor_enable(me),
.current_image_output(ci));
ldc3_host u_host(.clock,.wr_en,.wr_data(wd),.oc_flag_clear(fc),
.status_clear(st));
task chk(input logic [15:0] g,e);
samples_checked++;
if(g!==e) begin bad_count++;$display("[ERR] %0t got %h",$time,g);end
endtask
task n(input int k);
repeat(k) @(negedge clock);
endtask
function automatic logic [31:0] xs(input logic [31:0] v);
v^=v<<13;v^=v>>17;v^=v<<5;
return v;
endfunction
function automatic logic exp_mon(input int c);
return c<11;
endfunction
task trip;
ev=5'h10;n(1);chk(fl[4],1);
chk(dr[4],0);
ev=0;n(2);
endtask
task tally_and_finish;
$display("checks %0d errors %0d",samples_checked,bad_count);
if(bad_count==0&&samples_checked>0) $display("Result: passed");
else $display("Result: failed");
$finish;
endtask
always @(posedge clock) if(++cyc>3000) begin bad_count++;tally_and_finish;end
initial begin
n(10);rst=0;
for(int c=0;c<16;c++) begin
s=xs(s);
u_host.put({s[15:12],8'h0,c[3:0]});n(2);
chk(rd,{s[15:12],8'h0,c[3:0]});
chk(me,exp_mon(c));
chk(ci,c[3:0]);
end
$display("monitor done");
u_host.put(0);trip;n(30);u_host.clear(5'h10);n(2);
chk(fl[4],0);
chk(dr[4],1);
ev=5'h01;n(1);chk(fl[0],1);
chk(dr[0],0);
ev=0;u_host.clear(5'h01);n(1);chk(fl[0],0);
$display("manual clear done");
u_host.put(16'h8000);trip;n(60);
chk(fl[4],0);
chk(dr[4],1);
u_host.put(16'h8020);trip;n(9);
chk(fl[4],0);
$display("recovery done");
on=5'h00;n(2);chk(dr,0);
on=5'h1f;n(2);
u_host.put(16'h0200);pb=1;n(4);chk(dr[3],1);
pb=0;pa=1;n(4);chk(dr[3],0);
$display("pwm done");
u_host.put(16'h0010);sf=1;n(3);sf=0;n(3);chk(mb,1);
u_host.sclr;n(2);chk(mb,0);
$display("supply done");
ce=0;u_host.put(16'h1234);n(2);chk(rd,16'h0010);
ce=1;n(2);chk(rd,16'h0010);
$display("freeze done");
tally_and_finish;
end
endmodule
`default_nettype wire
